// ==== verilog/sls_pkg.sv ====
// Purpose: Shared constants and carrier types for the slope line setup unit.
// Assumes: One core clock; register words are 32 bits wide.
// Notes:   Register indices select one 32-bit register each.
package sls_pkg;
   localparam int          REG_IDX_W       = 5;
   // -----------------------------------------------------------------
   // Register indices
   // -----------------------------------------------------------------
   localparam logic [4:0]  IDX_SLOPE_DRAW  = 5'h00;  // 5'h00..5'h07, one per octant.
   localparam logic [4:0]  IDX_SLOPE_SETUP = 5'h08;  // 5'h08..5'h0f, one per octant.
   localparam logic [4:0]  IDX_ADDRESS     = 5'h10;
   localparam logic [4:0]  IDX_PATTERN     = 5'h11;
   localparam logic [4:0]  IDX_RASTER_OP   = 5'h12;
   localparam logic [4:0]  IDX_PLANE_MASK  = 5'h13;
   localparam logic [4:0]  IDX_FOREGROUND  = 5'h14;
   localparam logic [4:0]  IDX_BACKGROUND  = 5'h15;
   localparam logic [4:0]  IDX_BMP_WIDTH   = 5'h16;
   localparam logic [4:0]  IDX_MODE        = 5'h17;
   localparam logic [4:0]  IDX_DEPTH       = 5'h18;
   localparam logic [4:0]  IDX_BRES_ONE    = 5'h19;
   localparam logic [4:0]  IDX_BRES_TWO    = 5'h1a;
   localparam logic [4:0]  IDX_BRES_THREE  = 5'h1b;
   localparam logic [4:0]  IDX_STATUS      = 5'h1c;
   // -----------------------------------------------------------------
   // Field positions and values
   // -----------------------------------------------------------------
   localparam int          MODE_CAP_ENDS   = 15;
   localparam int          MODE_GFX_ENV    = 16;
   localparam int          DEPTH_WIDE      = 0;
   localparam logic [15:0] STEP_WIDE       = 16'h0004;
   localparam logic [15:0] STEP_NARROW     = 16'h0001;
   localparam logic [4:0]  SEG_PIXELS      = 5'h10;
   localparam logic [31:0] RESET_WORD      = 32'h0000_0000;

   typedef enum logic [1:0] {
      SLS_IDLE = 2'b01,
      SLS_DRAW = 2'b10
   } sls_state_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  idx;
      logic [31:0] wdata;
   } sls_reg_req_t;

   typedef struct packed {
      logic        we;
      logic [31:0] addr;
      logic [31:0] data;
      logic [31:0] plane_mask;
      logic [3:0]  rop;
      logic [3:0]  dst_fmt;
   } sls_pix_t;

   typedef struct packed {
      logic [15:0] addr_inc1;
      logic [15:0] err_inc1;
      logic [15:0] addr_inc2;
      logic [15:0] err_inc2;
      logic [15:0] init_err;
      logic [3:0]  length;
   } sls_terms_t;
endpackage : sls_pkg

// ==== verilog/sls_line_setup.sv ====
// Purpose: Slope register line setup and opaque segment drawing of up to 15 pixels.
// Assumes: Register requests and pixel writes are synchronous to clk_sys.
// Notes:   A slope write while a segment is drawing is ignored.
`timescale 1ns/100ps

// Behaviour
// - Slope draw write starts segment draw.
// - Rise in upper half, run lower half.
// - Address and pattern come from registers.
// - Pixel byte step four wide, else one.
// - Larger delta is major; flag nonzero deltas.
// - Address step magnitudes follow dominant axis.
// - Bias bit depends on graphics environment.
// - Length is major plus cap ends mod 16.
// - Error increments are minor, major minus minor.
// - Initial error from doubled minor, shifted.
// - First address increment negated when major zero.
// - Second increment adds signed minor step.
// - Computed terms stored in readable registers.
// - Draw runs standard stepping after setup.
// - Setup-only slope write computes, draws nothing.
// - Source settings ignored; destination from registers.
// - Mask bit picks foreground or background.
// - Negative error steps major, else diagonal.
// - Decrement length each pixel until zero.
// - Segment end leaves next address, length 16.
module sls_line_setup
   import sls_pkg::*;
(
   input  wire logic         clk_sys,    // Core clock, 20 MHz.
   input  wire logic         rst_n,      // Asynchronous reset, active low.
   input  wire logic         ce,         // Clock enable; state holds while low.
   input  wire sls_reg_req_t reg_req,    // Register write or read request.
   output      logic [31:0]  reg_rdata,  // Read data, one cycle after the read.
   output      logic         busy,       // Segment draw in progress.
   output      sls_pix_t     pix         // Pixel write to the frame buffer.
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      sls_state_t  st;
      logic [31:0] address;
      logic [31:0] pattern;
      logic [11:0] rop;
      logic [31:0] plane_mask;
      logic [31:0] fg;
      logic [31:0] bg;
      logic [15:0] bmp_width;
      logic [31:0] mode;
      logic        wide;
      sls_terms_t  terms;
      logic [2:0]  octant;
      logic [31:0] w_addr;
      logic [15:0] w_err;
      logic [4:0]  w_len;
      logic [15:0] w_mask;
      logic [31:0] d_fg;
      logic [31:0] d_bg;
      logic [31:0] d_pmask;
      logic [11:0] d_rop;
      logic [31:0] rdata;
      sls_pix_t    pix;
   } sls_regs_t;

   sls_regs_t r_q;
   sls_regs_t r_d;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   function automatic logic [15:0] sls_neg(input logic [15:0] v);
      sls_neg = ~v + 16'h0001;
   endfunction : sls_neg

   function automatic logic [15:0] sls_signed_mag(input logic pos, input logic [15:0] v);
      sls_signed_mag = pos ? v : sls_neg(v);
   endfunction : sls_signed_mag

   function automatic logic [31:0] sls_sext(input logic [15:0] v);
      sls_sext = {{16{v[15]}}, v};
   endfunction : sls_sext

   function automatic logic [15:0] sls_hi(input logic [31:0] w);
      sls_hi = w[31:16];
   endfunction : sls_hi

   function automatic logic [15:0] sls_lo(input logic [31:0] w);
      sls_lo = w[15:0];
   endfunction : sls_lo

   function automatic logic [31:0] sls_pack(input logic [15:0] hi, input logic [15:0] lo);
      sls_pack = {hi, lo};
   endfunction : sls_pack

   // Indices 5'h00..5'h0f are the slope registers; bit 3 set marks a setup-only one.
   function automatic logic sls_is_slope(input logic [4:0] idx);
      sls_is_slope = (idx[4] == 1'h0);
   endfunction : sls_is_slope

   function automatic logic sls_is_draw(input logic [4:0] idx);
      sls_is_draw = sls_is_slope(idx) && (idx[3] == 1'h0);
   endfunction : sls_is_draw

   function automatic logic [31:0] sls_colour(input logic bit_on, input logic [31:0] fg,
                                              input logic [31:0] bg);
      sls_colour = bit_on ? fg : bg;
   endfunction : sls_colour

   // Status word: working length in [31:27], last octant in [18:16], busy in [0].
   function automatic logic [31:0] sls_status(input logic [4:0] len, input logic [2:0] oct,
                                              input logic drawing);
      sls_status = {len, 8'h00, oct, 15'h0000, drawing};
   endfunction : sls_status

   // ----------------------------------------------------------------
   // Setup arithmetic
   // ----------------------------------------------------------------
   sls_terms_t  calc;
   logic [15:0] rise;
   logic [15:0] run;
   logic [15:0] dmajor;
   logic [15:0] dminor;
   logic [15:0] amajor;
   logic [15:0] aminor;
   logic [15:0] pix_step;
   logic [15:0] err_sum;
   logic        run_dom;
   logic        run_nz;
   logic        rise_nz;
   logic        major_nz;
   logic        minor_nz;
   logic        bias;

   always_comb begin
      rise     = sls_hi(reg_req.wdata);
      run      = sls_lo(reg_req.wdata);
      pix_step = r_q.wide ? STEP_WIDE : STEP_NARROW;
      run_dom  = run >= rise;
      run_nz   = run != 16'h0000;
      rise_nz  = rise != 16'h0000;
      dmajor   = run_dom ? run : rise;
      dminor   = run_dom ? rise : run;
      major_nz = run_dom ? run_nz : rise_nz;
      minor_nz = run_dom ? rise_nz : run_nz;
      amajor   = run_dom ? pix_step : r_q.bmp_width;
      aminor   = run_dom ? r_q.bmp_width : pix_step;
      if (r_q.mode[MODE_GFX_ENV]) begin
         bias = run_dom ? rise_nz : !run_nz;
      end else begin
         bias = major_nz;
      end
      // Sums wrap at 16 bits, the length sum at 4 bits, so every term fits its register field.
      calc.length    = dmajor[3:0] + {3'b000, r_q.mode[MODE_CAP_ENDS]};
      calc.err_inc1  = dminor;
      calc.err_inc2  = dmajor + sls_neg(dminor);
      err_sum        = {dminor[14:0], 1'b0} + ~dmajor + {15'h0000, bias};
      calc.init_err  = {err_sum[15], err_sum[15:1]};
      calc.addr_inc1 = sls_signed_mag(major_nz, amajor);
      calc.addr_inc2 = sls_signed_mag(minor_nz, aminor) + calc.addr_inc1;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic        slope_wr;
   logic        draw_wr;
   logic        err_neg;
   logic [31:0] step;
   logic [15:0] err_next;

   always_comb begin
      r_d        = r_q;
      r_d.pix.we = 1'h0;
      slope_wr   = reg_req.wr && sls_is_slope(reg_req.idx);
      draw_wr    = reg_req.wr && sls_is_draw(reg_req.idx);
      err_neg    = r_q.w_err[15];
      if (err_neg) begin
         step     = sls_sext(r_q.terms.addr_inc1);
         err_next = r_q.w_err + r_q.terms.err_inc1;
      end else begin
         step     = sls_sext(r_q.terms.addr_inc2);
         err_next = r_q.w_err - r_q.terms.err_inc2;
      end

      // ----------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------
      if (reg_req.wr && !slope_wr) begin
         unique case (reg_req.idx)
            IDX_ADDRESS:    r_d.address    = reg_req.wdata;
            IDX_PATTERN:    r_d.pattern    = reg_req.wdata;
            IDX_RASTER_OP:  r_d.rop        = reg_req.wdata[11:0];
            IDX_PLANE_MASK: r_d.plane_mask = reg_req.wdata;
            IDX_FOREGROUND: r_d.fg         = reg_req.wdata;
            IDX_BACKGROUND: r_d.bg         = reg_req.wdata;
            IDX_BMP_WIDTH:  r_d.bmp_width  = reg_req.wdata[15:0];
            IDX_MODE:       r_d.mode       = reg_req.wdata;
            IDX_DEPTH:      r_d.wide       = reg_req.wdata[DEPTH_WIDE];
            IDX_BRES_ONE: begin
               r_d.terms.addr_inc1 = sls_hi(reg_req.wdata);
               r_d.terms.err_inc1  = sls_lo(reg_req.wdata);
            end
            IDX_BRES_TWO: begin
               r_d.terms.addr_inc2 = sls_hi(reg_req.wdata);
               r_d.terms.err_inc2  = sls_lo(reg_req.wdata);
            end
            IDX_BRES_THREE: begin
               r_d.terms.init_err = sls_hi(reg_req.wdata);
               r_d.terms.length   = reg_req.wdata[3:0];
            end
            default: ;
         endcase
      end

      // ----------------------------------------------------------------
      // Segment state machine
      // ----------------------------------------------------------------
      unique case (r_q.st)
         SLS_IDLE: begin
            // Drawing samples its parameters once, so a slope write mid-draw is dropped.
            if (slope_wr) begin
               r_d.terms  = calc;
               r_d.octant = reg_req.idx[2:0];
            end
            if (draw_wr) begin
               r_d.st      = SLS_DRAW;
               r_d.w_addr  = r_q.address;
               r_d.w_mask  = r_q.pattern[15:0];
               r_d.w_err   = calc.init_err;
               // Length and error reload on every draw write; segments are never extended.
               r_d.w_len   = {1'h0, calc.length};
               r_d.d_fg    = r_q.fg;
               r_d.d_bg    = r_q.bg;
               r_d.d_pmask = r_q.plane_mask;
               r_d.d_rop   = r_q.rop;
            end
         end
         SLS_DRAW: begin
            if (r_q.w_len == 5'h00) begin
               r_d.st    = SLS_IDLE;
               r_d.w_len = SEG_PIXELS;
            end else begin
               r_d.pix.we         = 1'b1;
               r_d.pix.addr       = r_q.w_addr;
               r_d.pix.data       = sls_colour(r_q.w_mask[0], r_q.d_fg, r_q.d_bg);
               r_d.pix.plane_mask = r_q.d_pmask;
               r_d.pix.rop        = r_q.d_rop[3:0];
               r_d.pix.dst_fmt    = r_q.d_rop[11:8];
               r_d.w_mask         = {1'b0, r_q.w_mask[15:1]};
               r_d.w_addr         = r_q.w_addr + step;
               r_d.w_err          = err_next;
               r_d.w_len          = r_q.w_len - 5'h01;
            end
         end
      endcase

      // ----------------------------------------------------------------
      // Register reads
      // ----------------------------------------------------------------
      r_d.rdata = RESET_WORD;
      if (reg_req.rd) begin
         unique case (reg_req.idx)
            IDX_ADDRESS:    r_d.rdata = r_q.address;
            IDX_PATTERN:    r_d.rdata = r_q.pattern;
            IDX_RASTER_OP:  r_d.rdata = {20'h00000, r_q.rop};
            IDX_PLANE_MASK: r_d.rdata = r_q.plane_mask;
            IDX_FOREGROUND: r_d.rdata = r_q.fg;
            IDX_BACKGROUND: r_d.rdata = r_q.bg;
            IDX_BMP_WIDTH:  r_d.rdata = {16'h0000, r_q.bmp_width};
            IDX_MODE:       r_d.rdata = r_q.mode;
            IDX_DEPTH:      r_d.rdata = {31'h00000000, r_q.wide};
            IDX_BRES_ONE:   r_d.rdata = sls_pack(r_q.terms.addr_inc1,
                                                 r_q.terms.err_inc1);
            IDX_BRES_TWO:   r_d.rdata = sls_pack(r_q.terms.addr_inc2,
                                                 r_q.terms.err_inc2);
            IDX_BRES_THREE: r_d.rdata = sls_pack(r_q.terms.init_err,
                                                 {12'h000, r_q.terms.length});
            IDX_STATUS:     r_d.rdata = sls_status(r_q.w_len, r_q.octant, r_q.st == SLS_DRAW);
            default:        r_d.rdata = RESET_WORD;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r_q       <= '0;
         r_q.st    <= SLS_IDLE;
         r_q.w_len <= SEG_PIXELS;
      end else if (ce) begin
         // Gating the whole copy keeps pix.we and every working term frozen together.
         r_q <= r_d;
      end
   end

   assign reg_rdata = r_q.rdata;
   // The one-hot draw bit is a flop of its own, so busy needs no decode.
   assign busy      = r_q.st[1];
   assign pix       = r_q.pix;

endmodule : sls_line_setup

// ==== tb/sls_line_setup_monitor.sv ====
// Purpose: Port assertions for the slope line setup unit.
// Assumes: Sees only the top module ports; ce drops only while no segment draws.
// Notes:   Bound to every instance of the unit.
`timescale 1ns/100ps
module sls_line_setup_chk
   import sls_pkg::*;
(
   input wire logic         clk_sys,   // Core clock.
   input wire logic         rst_n,     // Reset, active low.
   input wire logic         ce,        // Clock enable.
   input wire sls_reg_req_t reg_req,   // Register request.
   input wire logic [31:0]  reg_rdata, // Read data.
   input wire logic         busy,      // Draw in progress.
   input wire sls_pix_t     pix        // Pixel write.
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_draw_req;
      ce && reg_req.wr && reg_req.idx < IDX_SLOPE_SETUP && !busy;
   endsequence
   sequence s_setup_req;
      ce && reg_req.wr && reg_req.idx[4:3] == 2'b01 && !busy;
   endsequence
   a_draw_sets_busy: assert property (s_draw_req |=> busy)
      else $error("busy missing after a draw write");
   a_first_pixel: assert property (s_draw_req |=> ##1 (pix.we || !busy))
      else $error("no first pixel after a draw write");
   a_setup_no_draw: assert property (s_setup_req |=> !busy ##1 !pix.we)
      else $error("setup write started a draw");
   a_we_in_draw: assert property (pix.we |-> busy)
      else $error("pixel write outside a draw");
   a_busy_bounded: assert property ($rose(busy) |-> ##[1:17] !busy)
      else $error("segment longer than its length field allows");
   a_fields_hold: assert property (!pix.we |-> $stable(pix.addr) && $stable(pix.data))
      else $error("pixel fields moved without a write");
   a_read_idle_zero: assert property (ce && !reg_req.rd |=> reg_rdata == 32'h0)
      else $error("read data not zero without a read");
   a_slope_write_only: assert property (ce && reg_req.rd && reg_req.idx < 5'h10
      |=> reg_rdata == 32'h0)
      else $error("slope register returned data");
endmodule : sls_line_setup_chk

bind sls_line_setup sls_line_setup_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .busy(busy), .pix(pix));

// ==== tb/sls_fb_model.sv ====
// Purpose: Frame buffer sink that logs the pixel writes of one segment.
// Assumes: At most one pixel write per cycle, fifteen per segment.
// Notes:   Any register write empties the log, so a draw starts clean.
`timescale 1ns/100ps
module sls_fb_model
   import sls_pkg::*;
(
   input wire logic     clk_sys, // Core clock.
   input wire logic     clr,     // Empties the log.
   input wire sls_pix_t pix      // Pixel write from the unit.
);
   sls_pix_t log_q [0:15];
   int       count = 0;
   always @(posedge clk_sys) begin
      if (clr)
         count <= 0;
      else if (pix.we) begin
         log_q[count[3:0]] <= pix;
         count <= count + 1;
      end
   end
endmodule : sls_fb_model

// ==== tb/sls_line_setup_test.sv ====
// Purpose: Register level tests of slope setup and segment drawing.
// Assumes: ce high except in one idle freeze check; no writes while a segment draws.
// Notes:   Expected terms are rebuilt here from rise, run and modes.
`timescale 1ns/100ps
module sls_line_setup_test;
   import sls_pkg::*;
   localparam logic [15:0] BW = 16'h0400;
   logic         clk_sys = 1'b0;
   logic         rst_n = 1'b0;
   logic         ce    = 1'b1;
   sls_reg_req_t reg_req = '0;
   logic [31:0]  reg_rdata, rd, ea;
   logic         busy;
   sls_pix_t     pix;
   sls_terms_t   t;
   int           fail_count = 0;
   int           checks_done = 0;
   always #25 clk_sys = ~clk_sys;
   sls_line_setup dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .busy(busy), .pix(pix));
   sls_fb_model fb (.clk_sys(clk_sys), .clr(reg_req.wr), .pix(pix));
   task automatic close_out;
      $display("checks %0d failures %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] idx, input logic [31:0] d);
      @(posedge clk_sys);
      #1 reg_req = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
      @(posedge clk_sys);
      #1 reg_req.wr = 1'b0;
   endtask : wr
   task automatic rdr(input logic [4:0] idx);
      @(posedge clk_sys);
      #1 reg_req = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 32'h0};
      @(posedge clk_sys);
      #1 reg_req.rd = 1'b0;
      rd = reg_rdata;
   endtask : rdr
   // Modes: wide pixels, last pixel drawn, graphics environment.
   task automatic cfg(input logic wide, input logic cap, input logic genv);
      wr(IDX_MODE, {15'h0, genv, cap, 15'h0});
      wr(IDX_DEPTH, {31'h0, wide});
   endtask : cfg
   function automatic sls_terms_t calc(input logic [15:0] ry, input logic [15:0] rx,
                                       input logic wide, input logic cap, input logic genv);
      logic        dom;
      logic [15:0] mj, mn, am, an, s;
      sls_terms_t  r;
      dom = rx >= ry;
      mj = dom ? rx : ry;
      mn = dom ? ry : rx;
      am = dom ? (wide ? STEP_WIDE : STEP_NARROW) : BW;
      an = dom ? BW : (wide ? STEP_WIDE : STEP_NARROW);
      s = (mn << 1) + ~mj + 16'(genv ? (dom ? ry != 0 : rx == 0) : mj != 0);
      r.length = 4'(mj + 16'(cap));
      r.err_inc1 = mn;
      r.err_inc2 = mj - mn;
      r.init_err = {s[15], s[15:1]};
      r.addr_inc1 = (mj != 0) ? am : -am;
      r.addr_inc2 = ((mn != 0) ? an : -an) + r.addr_inc1;
      return r;
   endfunction : calc
   task automatic check_terms(input sls_terms_t e);
      rdr(IDX_BRES_ONE);
      chk(rd, {e.addr_inc1, e.err_inc1});
      rdr(IDX_BRES_TWO);
      chk(rd, {e.addr_inc2, e.err_inc2});
      rdr(IDX_BRES_THREE);
      chk(rd & 32'hffff_000f, {e.init_err, 12'h0, e.length});
   endtask : check_terms
   initial begin
      logic [15:0] ry, rx, er, pat;
      int          k;
      repeat (8) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      wr(IDX_BMP_WIDTH, {16'h0, BW});
      for (int o = 0; o < 8; o++) begin
         ry = 16'(3 * o);
         rx = 16'(19 - 2 * o);
         cfg(o[0], o[1], o[2]);
         wr(IDX_SLOPE_SETUP + 5'(o), {ry, rx});
         chk({31'h0, busy}, 32'h0);
         check_terms(calc(ry, rx, o[0], o[1], o[2]));
      end
      wr(IDX_RASTER_OP, 32'h0000_0a05);
      wr(IDX_PLANE_MASK, 32'h00ff_ff00);
      wr(IDX_FOREGROUND, 32'h1111_1111);
      wr(IDX_BACKGROUND, 32'h2222_2222);
      for (int o = 0; o < 8; o++) begin
         ry = 16'(o + 1);
         rx = 16'(7 - o);
         pat = 16'h5a3c ^ 16'(o);
         cfg(o[2], o[0], o[1]);
         wr(IDX_ADDRESS, 32'h0000_1000 + 32'(o));
         wr(IDX_PATTERN, {16'hffff, pat});
         t = calc(ry, rx, o[2], o[0], o[1]);
         wr(IDX_SLOPE_DRAW + 5'(o), {ry, rx});
         chk({31'h0, busy}, 32'h1);
         for (k = 0; busy === 1'b1 && k < 40; k++) begin
            @(posedge clk_sys);
            #1;
         end
         chk(32'(k), 32'(t.length) + 32'h1);
         chk(32'(fb.count), 32'(t.length));
         chk(fb.log_q[0].plane_mask, 32'h00ff_ff00);
         chk({20'h0, fb.log_q[0].dst_fmt, 4'h0, fb.log_q[0].rop}, 32'h0a05);
         ea = 32'h0000_1000 + 32'(o);
         er = t.init_err;
         for (int p = 0; p < 32'(t.length); p++) begin
            chk(fb.log_q[p].addr, ea);
            chk(fb.log_q[p].data, pat[p] ? 32'h1111_1111 : 32'h2222_2222);
            if (er[15]) begin
               ea = ea + {{16{t.addr_inc1[15]}}, t.addr_inc1};
               er = er + t.err_inc1;
            end else begin
               ea = ea + {{16{t.addr_inc2[15]}}, t.addr_inc2};
               er = er - t.err_inc2;
            end
         end
         check_terms(t);
         rdr(IDX_STATUS);
         chk({27'h0, rd[31:27]}, 32'h10);
         chk({29'h0, rd[18:16]}, 32'(o));
         chk({31'h0, rd[0]}, 32'h0);
      end
      rdr(5'h1e);
      chk(rd, 32'h0);
      rdr(IDX_SLOPE_DRAW);
      chk(rd, 32'h0);
      // A slope write while the clock enable is low must neither draw nor set up.
      ce = 1'b0;
      wr(IDX_SLOPE_DRAW, 32'h0001_0002);
      ce = 1'b1;
      chk({31'h0, busy}, 32'h0);
      check_terms(t);
      close_out();
   end
   initial begin
      #250000;
      fail_count++;
      close_out();
   end
endmodule : sls_line_setup_test
